// >>> dmact_channel.sv
// One DMA channel: AXI4-Lite slave for programming, simple master port for transfers
//
// Implementation choices: the placing of the registers and the AXI4-Lite interface to the registers.
module dmact_channel #(
  parameter int BCW = 20
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  input wire logic periph_req,
  output dmact_pkg::dmact_mreq_s m_req,
  output logic [3:0] m_strb,
  input wire dmact_pkg::dmact_mrsp_s m_rsp,
  output logic irq
);
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_RD = 5'b00010,
    ST_WR = 5'b00100,
    ST_NEXT = 5'b01000,
    ST_HALT = 5'b10000
  } dmact_st_e;

  dmact_st_e st_ff;
  logic [31:0] sar_ff;
  logic [31:0] dar_ff;
  logic [BCW-1:0] byte_count_ff;
  logic [31:0] channel_control_word_ff;
  logic done_ff;
  logic source_bus_error_flag_ff;
  logic dest_bus_error_flag_ff;
  logic [2:0] msk_ff;
  logic [31:0] hold_ff;
  logic pend_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic aw_ok_ff;
  logic w_ok_ff;
  logic bvalid_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  dmact_pkg::dmact_mreq_s mreq_ff;
  logic [3:0] mstrb_ff;

  logic [31:0] src_unit;
  logic [31:0] dst_lane;
  logic [3:0] dst_strb;
  logic [2:0] dst_nb;
  logic [2:0] src_nb;

  logic wr_fire;
  logic done_clear;
  logic start_wr;
  logic req_in;
  logic flags_pend;
  logic may_start;
  logic [BCW-1:0] nxt_count;
  logic [1:0] ssize;
  logic [1:0] dsize;

  assign ssize = channel_control_word_ff[dmact_pkg::CTL_SSIZE +: 2];
  assign dsize = channel_control_word_ff[dmact_pkg::CTL_DSIZE +: 2];

  dmact_lane u_src (
    .size(ssize),
    .addr_lo(sar_ff[1:0]),
    .bus_data(m_rsp.rdata),
    .unit_in(32'h0000_0000),
    .unit_out(src_unit),
    .lane_out(),
    .strb(),
    .nbytes()
  );
  dmact_lane u_dst (
    .size(dsize),
    .addr_lo(dar_ff[1:0]),
    .bus_data(32'h0000_0000),
    .unit_in(hold_ff),
    .unit_out(),
    .lane_out(dst_lane),
    .strb(dst_strb),
    .nbytes(dst_nb)
  );

  function automatic logic [2:0] size_bytes(input logic [1:0] sz);
    case (sz)
      dmact_pkg::SZ_8: size_bytes = 3'd1;
      dmact_pkg::SZ_16: size_bytes = 3'd2;
      default: size_bytes = 3'd4;
    endcase
  endfunction
  assign src_nb = size_bytes(ssize);

  // Register bus: address and data may arrive in either order
  assign s_awready = !aw_ok_ff && !bvalid_ff;
  assign s_wready = !w_ok_ff && !bvalid_ff;
  assign wr_fire = aw_ok_ff && w_ok_ff && !bvalid_ff;
  assign s_bvalid = bvalid_ff;
  assign s_bresp = dmact_pkg::AXI_OKAY;
  assign s_arready = !rvalid_ff;
  assign s_rvalid = rvalid_ff;
  assign s_rdata = rdata_ff;
  assign s_rresp = rresp_ff;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      aw_ok_ff <= 1'b0;
      w_ok_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_ok_ff <= 1'b1;
        awaddr_ff <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_ok_ff <= 1'b1;
        wdata_ff <= s_wdata;
        wstrb_ff <= s_wstrb;
      end
      if (wr_fire) begin
        aw_ok_ff <= 1'b0;
        w_ok_ff <= 1'b0;
        bvalid_ff <= 1'b1;
      end else if (bvalid_ff && s_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= dmact_pkg::AXI_OKAY;
    end else if (s_arvalid && s_arready) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= dmact_pkg::AXI_OKAY;
      case ({s_araddr[7:2], 2'b00})
        dmact_pkg::ADDR_SAR: rdata_ff <= sar_ff;
        dmact_pkg::ADDR_DAR: rdata_ff <= dar_ff;
        dmact_pkg::ADDR_BYTE_COUNT: rdata_ff <= 32'(byte_count_ff);
        dmact_pkg::ADDR_CTL: rdata_ff <= channel_control_word_ff;
        dmact_pkg::ADDR_STA: rdata_ff <= {28'h000_0000, st_ff != ST_IDLE,
          dest_bus_error_flag_ff, source_bus_error_flag_ff, done_ff};
        dmact_pkg::ADDR_MSK: rdata_ff <= {29'h0000_0000, msk_ff};
        default: begin
          rdata_ff <= 32'h0000_0000;
          rresp_ff <= dmact_pkg::AXI_SLVERR;
        end
      endcase
    end else if (rvalid_ff && s_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // Other registers take whole words; a status write without its low byte clears nothing
  function automatic logic wstrb_ok(input logic [3:0] strb_in);
    wstrb_ok = strb_in[0];
  endfunction

  assign done_clear = wr_fire && ({awaddr_ff[7:2], 2'b00} == dmact_pkg::ADDR_STA)
    && wstrb_ok(wstrb_ff) && wdata_ff[dmact_pkg::STA_DONE];
  assign start_wr = wr_fire && ({awaddr_ff[7:2], 2'b00} == dmact_pkg::ADDR_CTL)
    && wdata_ff[dmact_pkg::CTL_START];

  // Request capture
  assign flags_pend = done_ff || source_bus_error_flag_ff || dest_bus_error_flag_ff;
  assign may_start = (byte_count_ff != '0) && !flags_pend;
  assign req_in = start_wr
    || (periph_req && channel_control_word_ff[dmact_pkg::CTL_PREQ_EN]);

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pend_ff <= 1'b0;
    end else if (flags_pend || byte_count_ff == '0) begin
      pend_ff <= 1'b0;
    end else if (req_in) begin
      pend_ff <= 1'b1;
    end else if (st_ff == ST_IDLE && pend_ff) begin
      pend_ff <= 1'b0;
    end
  end

  assign nxt_count = (byte_count_ff > BCW'(dst_nb)) ? byte_count_ff - BCW'(dst_nb) : '0;

  // Transfer engine
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= ST_IDLE;
      mreq_ff <= '0;
      mstrb_ff <= 4'h0;
      hold_ff <= 32'h0000_0000;
    end else begin
      case (st_ff)
        ST_IDLE: begin
          if (pend_ff && may_start) begin
            st_ff <= ST_RD;
            mreq_ff <= '{valid: 1'b1, write: 1'b0, addr: sar_ff, wdata: 32'h0000_0000,
              size: ssize};
            mstrb_ff <= 4'h0;
          end
        end
        ST_RD: begin
          if (m_rsp.done) begin
            mreq_ff.valid <= 1'b0;
            if (m_rsp.err) begin
              st_ff <= ST_HALT;
            end else begin
              hold_ff <= src_unit;
              st_ff <= ST_WR;
            end
          end
        end
        ST_WR: begin
          if (!mreq_ff.valid) begin
            mreq_ff <= '{valid: 1'b1, write: 1'b1, addr: dar_ff, wdata: dst_lane,
              size: dsize};
            mstrb_ff <= dst_strb;
          end else if (m_rsp.done) begin
            mreq_ff.valid <= 1'b0;
            mstrb_ff <= 4'h0;
            st_ff <= m_rsp.err ? ST_HALT : ST_NEXT;
            if (m_rsp.err) begin
              hold_ff <= 32'h0000_0000;
            end
          end
        end
        ST_NEXT: begin
          // Cycle-steal returns to idle; continuous keeps going
          if (channel_control_word_ff[dmact_pkg::CTL_CS] || byte_count_ff == '0) begin
            st_ff <= ST_IDLE;
          end else begin
            st_ff <= ST_RD;
            mreq_ff <= '{valid: 1'b1, write: 1'b0, addr: sar_ff, wdata: 32'h0000_0000,
              size: ssize};
          end
        end
        ST_HALT: st_ff <= ST_IDLE;
        default: st_ff <= ST_IDLE;
      endcase
    end
  end

  // Programming registers and counting
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sar_ff <= 32'h0000_0000;
      dar_ff <= 32'h0000_0000;
      byte_count_ff <= '0;
      channel_control_word_ff <= dmact_pkg::CTL_RST;
      msk_ff <= dmact_pkg::MSK_RST;
    end else begin
      if (wr_fire) begin
        case ({awaddr_ff[7:2], 2'b00})
          dmact_pkg::ADDR_SAR: sar_ff <= wdata_ff;
          dmact_pkg::ADDR_DAR: dar_ff <= wdata_ff;
          dmact_pkg::ADDR_BYTE_COUNT: byte_count_ff <= wdata_ff[BCW-1:0];
          // Start is self-clearing
          dmact_pkg::ADDR_CTL: channel_control_word_ff <= wdata_ff & ~32'h0000_0001;
          dmact_pkg::ADDR_MSK: msk_ff <= wdata_ff[2:0];
          default: ;
        endcase
      end
      if (st_ff == ST_RD && m_rsp.done && !m_rsp.err
          && channel_control_word_ff[dmact_pkg::CTL_SINC]) begin
        sar_ff <= sar_ff + 32'(src_nb);
      end
      if (st_ff == ST_WR && mreq_ff.valid && m_rsp.done && !m_rsp.err) begin
        byte_count_ff <= nxt_count;
        if (channel_control_word_ff[dmact_pkg::CTL_DINC]) begin
          dar_ff <= dar_ff + 32'(dst_nb);
        end
      end
    end
  end

  // Status flags: hardware set wins over software clear
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      done_ff <= 1'b0;
      source_bus_error_flag_ff <= 1'b0;
      dest_bus_error_flag_ff <= 1'b0;
    end else begin
      if (done_clear) begin
        done_ff <= 1'b0;
        source_bus_error_flag_ff <= 1'b0;
        dest_bus_error_flag_ff <= 1'b0;
      end
      if (st_ff == ST_WR && mreq_ff.valid && m_rsp.done && !m_rsp.err
          && nxt_count == '0) begin
        done_ff <= 1'b1;
      end
      if (st_ff == ST_RD && m_rsp.done && m_rsp.err) begin
        source_bus_error_flag_ff <= 1'b1;
        done_ff <= 1'b1;
      end
      if (st_ff == ST_WR && mreq_ff.valid && m_rsp.done && m_rsp.err) begin
        dest_bus_error_flag_ff <= 1'b1;
        done_ff <= 1'b1;
      end
    end
  end

  // Mask bit set means the event may interrupt
  assign irq = channel_control_word_ff[dmact_pkg::CTL_IEN]
    && |({dest_bus_error_flag_ff, source_bus_error_flag_ff, done_ff} & msk_ff);
  assign m_req = mreq_ff;
  assign m_strb = mstrb_ff;
endmodule // dmact_channel

// >>> dmact_pkg.sv
package dmact_pkg;
  localparam logic [7:0] ADDR_SAR = 8'h00;
  localparam logic [7:0] ADDR_DAR = 8'h04;
  localparam logic [7:0] ADDR_BYTE_COUNT = 8'h08;
  localparam logic [7:0] ADDR_CTL = 8'h0C;
  localparam logic [7:0] ADDR_STA = 8'h10;
  localparam logic [7:0] ADDR_MSK = 8'h14;
  // Control word bits
  localparam int CTL_START = 0;
  localparam int CTL_CS = 1;
  localparam int CTL_PREQ_EN = 2;
  localparam int CTL_IEN = 3;
  localparam int CTL_SINC = 4;
  localparam int CTL_DINC = 5;
  localparam int CTL_SSIZE = 8;
  localparam int CTL_DSIZE = 10;
  // Status bits
  localparam int STA_DONE = 0;
  localparam int STA_SRC_ERR = 1;
  localparam int STA_DST_ERR = 2;
  localparam int STA_BUSY = 3;
  localparam logic [31:0] CTL_RST = 32'h0000_0000;
  localparam logic [2:0] MSK_RST = 3'h7;
  localparam logic [1:0] SZ_32 = 2'h0;
  localparam logic [1:0] SZ_8 = 2'h1;
  localparam logic [1:0] SZ_16 = 2'h2;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [1:0] size;
  } dmact_mreq_s;
  typedef struct packed {
    logic done;
    logic err;
    logic [31:0] rdata;
  } dmact_mrsp_s;
endpackage

// >>> dmact_lane.sv
// Lane aligner: places a unit of the given size into byte lanes and back
module dmact_lane (
  input wire logic [1:0] size,
  input wire logic [1:0] addr_lo,
  input wire logic [31:0] bus_data,
  input wire logic [31:0] unit_in,
  output logic [31:0] unit_out,
  output logic [31:0] lane_out,
  output logic [3:0] strb,
  output logic [2:0] nbytes
);
  always_comb begin
    unit_out = bus_data;
    lane_out = unit_in;
    strb = 4'hF;
    nbytes = 3'd4;
    case (size)
      dmact_pkg::SZ_8: begin
        unit_out = {24'h00_0000, bus_data[addr_lo*8 +: 8]};
        lane_out = {4{unit_in[7:0]}};
        strb = 4'h1 << addr_lo;
        nbytes = 3'd1;
      end
      dmact_pkg::SZ_16: begin
        unit_out = {16'h0000, bus_data[addr_lo[1]*16 +: 16]};
        lane_out = {2{unit_in[15:0]}};
        strb = addr_lo[1] ? 4'hC : 4'h3;
        nbytes = 3'd2;
      end
      default: begin
        unit_out = bus_data;
        lane_out = unit_in;
        strb = 4'hF;
        nbytes = 3'd4;
      end
    endcase
  end
endmodule // dmact_lane

// >>> dmact_chk.sv
module dmact_chk (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic s_wvalid,
  input wire logic s_wready,
  input wire logic s_bvalid,
  input wire dmact_pkg::dmact_mreq_s m_req,
  input wire logic [3:0] m_strb,
  input wire dmact_pkg::dmact_mrsp_s m_rsp,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  logic rd_fin;
  logic wr_fin;
  logic swr;
  assign rd_fin = m_req.valid && !m_req.write && m_rsp.done;
  assign wr_fin = m_req.valid && m_req.write && m_rsp.done;
  assign swr = s_wvalid && s_wready;
  property p_hold;
    m_req.valid && !m_rsp.done |=> m_req.valid && $stable(m_req);
  endproperty
  a_hold: assert property (p_hold) else $error("request not held");
  property p_drop;
    m_req.valid && m_rsp.done |=> !m_req.valid;
  endproperty
  a_drop: assert property (p_drop) else $error("request not dropped");
  property p_rd_wr;
    rd_fin && !m_rsp.err |=> !m_req.valid ##1 (m_req.valid && m_req.write);
  endproperty
  a_rd_wr: assert property (p_rd_wr) else $error("no write after read");
  property p_rd_err;
    rd_fin && m_rsp.err |=> !m_req.valid [*8];
  endproperty
  a_rd_err: assert property (p_rd_err) else $error("run after read error");
  property p_wr_err;
    wr_fin && m_rsp.err |=> !m_req.valid [*8];
  endproperty
  a_wr_err: assert property (p_wr_err) else $error("held data written");
  property p_strb;
    m_req.valid && m_req.write |-> $countones(m_strb) ==
      (m_req.size == dmact_pkg::SZ_8 ? 1 : (m_req.size == dmact_pkg::SZ_16 ? 2 : 4));
  endproperty
  a_strb: assert property (p_strb) else $error("strobe width wrong");
  // Level irq can only move after a bus completion or a register write
  property p_irq_up;
    $rose(irq) |-> $past(m_rsp.done) || $past(s_bvalid) || $past(swr) || $past(swr, 2);
  endproperty
  a_irq_up: assert property (p_irq_up) else $error("irq rose without cause");
  property p_irq_dn;
    $fell(irq) |-> $past(s_bvalid) || $past(swr) || $past(swr, 2);
  endproperty
  a_irq_dn: assert property (p_irq_dn) else $error("irq fell without write");
endmodule // dmact_chk

bind dmact_channel dmact_chk i_dmact_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bvalid(s_bvalid), .m_req(m_req),
  .m_strb(m_strb), .m_rsp(m_rsp), .irq(irq));

// >>> dmact_mem.sv
module dmact_mem (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire dmact_pkg::dmact_mreq_s m_req,
  input wire logic [3:0] m_strb,
  input wire logic [3:0] lat,
  input wire logic [31:0] err_addr,
  output dmact_pkg::dmact_mrsp_s m_rsp
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [64];
  logic [3:0] wait_ff;
  int n_wr;
  // Byte at address a holds a, so expectations follow from addresses alone
  initial begin
    n_wr = 0;
    for (int i = 0; i < 64; i++) begin
      mem[i] = 32'h0302_0100 + {4{8'(i * 4)}};
    end
  end
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wait_ff <= 4'h0;
      m_rsp <= '0;
    end else if (m_req.valid && !m_rsp.done && wait_ff < lat) begin
      wait_ff <= wait_ff + 4'h1;
    end else if (m_req.valid && !m_rsp.done) begin
      wait_ff <= 4'h0;
      m_rsp.done <= 1'h1;
      m_rsp.err <= m_req.addr == err_addr;
      m_rsp.rdata <= mem[m_req.addr[7:2]];
      // Every write attempt counts, so a retried failing write shows up too
      if (m_req.write) begin
        n_wr <= n_wr + 1;
      end
      if (m_req.write && m_req.addr != err_addr) begin
        for (int k = 0; k < 4; k++) begin
          if (m_strb[k]) mem[m_req.addr[7:2]][8*k +: 8] <= m_req.wdata[8*k +: 8];
        end
      end
    end else begin
      // Released data lines toggle so a stale word is never mistaken for data
      m_rsp <= {2'h0, ~m_rsp.rdata};
    end
  end
endmodule // dmact_mem

// >>> dmact_channel_tb.sv
module dmact_channel_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'h0, sys_rst = 1'h1, periph_req = 1'h0;
  logic s_awvalid = 1'h0, s_wvalid = 1'h0, s_arvalid = 1'h0, s_bready = 1'h1, s_rready = 1'h1;
  logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
  logic [31:0] s_wdata = 32'h0000_0000, err_addr = 32'hFFFF_FFFC, rd;
  logic [3:0] lat = 4'h3;
  logic [1:0] rr, br, s_bresp, s_rresp;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, irq;
  logic [31:0] s_rdata;
  logic [3:0] m_strb;
  dmact_pkg::dmact_mreq_s m_req;
  dmact_pkg::dmact_mrsp_s m_rsp;
  int n_errors = 0, check_count = 0, n0, k;
  dmact_channel i_dmact_channel (.clk_sys(clk_sys), .sys_rst(sys_rst), .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(4'hF),
    .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
    .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .periph_req(periph_req), .m_req(m_req), .m_strb(m_strb), .m_rsp(m_rsp), .irq(irq));
  dmact_mem i_dmact_mem (.clk_sys(clk_sys), .sys_rst(sys_rst), .m_req(m_req),
    .m_strb(m_strb), .lat(lat), .err_addr(err_addr), .m_rsp(m_rsp));
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] cw(logic st, logic cs, logic pe, logic ie, logic [1:0] sz);
    return {20'h0_0000, sz, sz, 2'h0, 2'h3, ie, pe, cs, st};
  endfunction
  task automatic print_verdict;
    if (n_errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic hang(input int i);
    if (i >= 60) begin
      n_errors++;
      print_verdict;
    end
  endtask
  // Handshakes are judged at the falling edge, acted on at the next rising edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    logic ta, tw, tb;
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'h1;
    s_wvalid <= 1'h1;
    for (i = 0; i < 60; i++) begin
      @(negedge clk_sys);
      ta = s_awready;
      tw = s_wready;
      tb = s_bvalid;
      br = s_bresp;
      @(posedge clk_sys);
      if (ta) s_awvalid <= 1'h0;
      if (tw) s_wvalid <= 1'h0;
      if (tb) break;
    end
    hang(i);
  endtask
  task automatic axi_rd(input logic [7:0] a);
    int i;
    logic ta, tr;
    s_araddr <= a;
    s_arvalid <= 1'h1;
    for (i = 0; i < 60; i++) begin
      @(negedge clk_sys);
      ta = s_arready;
      tr = s_rvalid;
      rd = s_rdata;
      rr = s_rresp;
      @(posedge clk_sys);
      if (ta) s_arvalid <= 1'h0;
      if (tr) break;
    end
    hang(i);
  endtask
  task automatic prog(input logic [31:0] sa, da, bc, c);
    axi_wr(dmact_pkg::ADDR_SAR, sa);
    axi_wr(dmact_pkg::ADDR_DAR, da);
    axi_wr(dmact_pkg::ADDR_BYTE_COUNT, bc);
    axi_wr(dmact_pkg::ADDR_CTL, c);
  endtask
  task automatic sta(input logic [31:0] exp);
    axi_rd(dmact_pkg::ADDR_STA);
    chk(rd, exp);
  endtask
  task automatic wait_done;
    int i;
    for (i = 0; i < 60; i++) begin
      axi_rd(dmact_pkg::ADDR_STA);
      if (rd[0] === 1'h1) break;
    end
    hang(i);
  endtask
  initial begin
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'h0;
    @(posedge clk_sys);
    axi_rd(dmact_pkg::ADDR_CTL);
    chk(rd, dmact_pkg::CTL_RST);
    axi_rd(dmact_pkg::ADDR_MSK);
    chk(rd, {29'h0, dmact_pkg::MSK_RST});
    axi_rd(8'h18);
    chk({30'h0, rr}, {30'h0, dmact_pkg::AXI_SLVERR});
    prog(32'h0000_0000, 32'h0000_0080, 32'h0000_0008, cw(1'h1, 1'h0, 1'h0, 1'h1, 2'h0));
    wait_done;
    sta(32'h0000_0001);
    chk(i_dmact_mem.mem[33], 32'h0706_0504);
    axi_rd(dmact_pkg::ADDR_BYTE_COUNT);
    chk(rd, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0001);
    axi_wr(dmact_pkg::ADDR_STA, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0000);
    chk({30'h0, br}, {30'h0, dmact_pkg::AXI_OKAY});
    n0 = i_dmact_mem.n_wr;
    axi_wr(dmact_pkg::ADDR_CTL, cw(1'h1, 1'h0, 1'h0, 1'h1, 2'h0));
    repeat (30) @(posedge clk_sys);
    chk(i_dmact_mem.n_wr, n0);
    sta(32'h0000_0000);
    lat <= 4'h0;
    prog(32'h0000_0001, 32'h0000_0090, 32'h0000_0003, cw(1'h0, 1'h1, 1'h1, 1'h0, 2'h1));
    // One-cycle request: a level still high at the start edge would be taken again
    periph_req <= 1'h1;
    @(posedge clk_sys);
    periph_req <= 1'h0;
    for (k = 0; k < 60 && m_req.valid !== 1'h1; k++) @(negedge clk_sys);
    hang(k);
    repeat (20) @(posedge clk_sys);
    axi_rd(dmact_pkg::ADDR_BYTE_COUNT);
    chk(rd, 32'h0000_0002);
    chk({24'h0, i_dmact_mem.mem[36][7:0]}, 32'h0000_0001);
    axi_wr(dmact_pkg::ADDR_CTL, cw(1'h0, 1'h1, 1'h0, 1'h0, 2'h1));
    periph_req <= 1'h1;
    repeat (20) @(posedge clk_sys);
    periph_req <= 1'h0;
    axi_rd(dmact_pkg::ADDR_BYTE_COUNT);
    chk(rd, 32'h0000_0002);
    err_addr <= 32'h0000_0040;
    prog(32'h0000_0040, 32'h0000_00A0, 32'h0000_0004, cw(1'h1, 1'h0, 1'h0, 1'h1, 2'h0));
    wait_done;
    sta(32'h0000_0003);
    axi_wr(dmact_pkg::ADDR_MSK, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    axi_wr(dmact_pkg::ADDR_MSK, 32'h0000_0007);
    chk({31'h0, irq}, 32'h0000_0001);
    axi_wr(dmact_pkg::ADDR_STA, 32'h0000_0001);
    sta(32'h0000_0000);
    n0 = i_dmact_mem.n_wr;
    err_addr <= 32'h0000_00B0;
    prog(32'h0000_0010, 32'h0000_00B0, 32'h0000_0002, cw(1'h1, 1'h0, 1'h0, 1'h1, 2'h2));
    wait_done;
    sta(32'h0000_0005);
    axi_wr(dmact_pkg::ADDR_STA, 32'h0000_0001);
    repeat (20) @(posedge clk_sys);
    chk(i_dmact_mem.n_wr, n0 + 1);
    sta(32'h0000_0000);
    prog(32'h0000_0006, 32'h0000_00C0, 32'h0000_0002, cw(1'h1, 1'h0, 1'h0, 1'h0, 2'h2));
    wait_done;
    sta(32'h0000_0001);
    chk(i_dmact_mem.mem[48], 32'hC3C2_0706);
    chk({31'h0, irq}, 32'h0000_0000);
    n0 = i_dmact_mem.n_wr;
    axi_wr(dmact_pkg::ADDR_BYTE_COUNT, 32'h0000_0002);
    axi_wr(dmact_pkg::ADDR_CTL, cw(1'h1, 1'h0, 1'h0, 1'h0, 2'h2));
    repeat (30) @(posedge clk_sys);
    chk(i_dmact_mem.n_wr, n0);
    print_verdict;
  end
endmodule // dmact_channel_tb
